// File: common/srm_defines.svh
// Function
// - file shift right, zero msb, lsb to carry
// - destination bit selects default reg or file
// - size bit: word when 0, byte when 1
// - source form shifts by one, both addressable indirectly
// - one-position shifts update negative, zero, carry
// - short literal count 0..15, zero fill
// - count from low five bits of register
// - count above fifteen writes zero result
// - multi-bit forms: words, direct, carry untouched
// - product of six allowed register pairs accumulates
// - product sign-extended to forty bits, added
// - one instruction bit picks the accumulator
// - optional X/Y prefetch with pointer post-adjust
// - register-offset prefetch, pointers left untouched
// - other accumulator rounded, stored to register 13 or to memory at its address
// - overflow and clipped flags, combined flags updated
// - control bit 0 picks fractional or integer
// - square form squares one register, same prefetch
// - multiply word decoded from its fixed fields
`ifndef SRM_DEFINES_SVH
`define SRM_DEFINES_SVH

// ----------------------------------------------------------------
// register map (byte offsets on the bus)
// ----------------------------------------------------------------
`define SRM_OFF_INSTR    9'h000
`define SRM_OFF_STATUS   9'h004
`define SRM_OFF_CCR      9'h008
`define SRM_OFF_ACCUMULATOR_ONE_LO  9'h00c
`define SRM_OFF_ACCUMULATOR_ONE_HI  9'h010
`define SRM_OFF_ACCUMULATOR_TWO_LO  9'h014
`define SRM_OFF_ACCUMULATOR_TWO_HI  9'h018
`define SRM_DEFAULT_WORK_REG_PAGE    3'h1
`define SRM_MEM_BIT      8

// ----------------------------------------------------------------
// status fields and reset values
// ----------------------------------------------------------------
`define SRM_ST_C     0
`define SRM_ST_Z     1
`define SRM_ST_N     2
`define SRM_ST_ILL   3
`define SRM_ST_BUSY  4
`define SRM_ST_SAB   8
`define SRM_ST_OAB   9
`define SRM_ST_SB    10
`define SRM_ST_SA    11
`define SRM_ST_OB    12
`define SRM_ST_OA    13
`define SRM_CCR_IF   0
`define SRM_CCR_RST  16'h0000

// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define SRM_OP_LSRF   9'h1aa
`define SRM_OP_LSRW   9'h1a2
`define SRM_OP_LSRM   9'h1bc
`define SRM_OP_MAC    5'h18
`define SRM_OP_SQR    6'h3c
`define SRM_LSR_LIT   3'h4
`define SRM_LSR_CNT   3'h0
`define SRM_AM_DIR    3'h0
`define SRM_AM_POSTINC 3'h2
`define SRM_AM_POSTDEC 3'h3
`define SRM_AM_PREINC 3'h4
`define SRM_AM_PREDEC 3'h5
`define SRM_PF_NONE   4'h4
`define SRM_PF_OFS    4'hc
`define SRM_AWB_REG   2'h0
`define SRM_AWB_MEM   2'h1
`define SRM_MAX_SHIFT 5'h0f
`define SRM_DEFAULT_WORK_REG_DEF  4'h0
`define SRM_DEFAULT_WORK_REG_OFS  4'hc
`define SRM_DEFAULT_WORK_REG_AWB  4'hd
`define SRM_XPTR_HI   3'h4
`define SRM_YPTR_HI   3'h5
`define SRM_FACT_HI   2'h1
`define SRM_WORD_STEP 16'h0002
`define SRM_BYTE_STEP 16'h0001

`endif

// File: common/srm_pkg.sv
package srm_pkg;

  // ----------------------------------------------------------------
  // execution sequence and state records
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRM_IDLE, SRM_RD1, SRM_RD2, SRM_EXEC}
    srm_state_t;

  typedef logic [5:0] srm_maddr_t;

  typedef struct packed {
    srm_state_t        st;
    logic              busy;
    logic [1:0]        bph;
    logic              ack;
    logic [31:0]       dat;
    logic [23:0]       ir;
    logic [15:0][15:0] w;
    logic [39:0]       accumulator_one;
    logic [39:0]       accumulator_two;
    logic [15:0]       ccr;
    logic [15:0]       d1;
    logic              fn;
    logic              fz;
    logic              fc;
    logic              oa;
    logic              ob;
    logic              sa;
    logic              sb;
    logic              ill;
  } srm_regs_t;

  typedef struct packed {
    logic [63:0][15:0] word;
    logic [15:0]       rdata;
  } srm_mem_t;

endpackage

// File: common/srm_mem_if.sv
`timescale 1ns/10ps

interface srm_mem_if;
  import srm_pkg::*;
  srm_maddr_t  addr;
  logic [15:0] wdata;
  logic [1:0]  be;
  logic        we;
  logic [15:0] rdata;
  modport ctl (output addr, output wdata, output be, output we,
               input rdata);
  modport mem (input addr, input wdata, input be, input we,
               output rdata);
endinterface

// File: hdl/srm_dmem.sv
`timescale 1ns/10ps

module srm_dmem import srm_pkg::*; (
  input wire logic clk,
  srm_mem_if.mem   port
);

  srm_mem_t    m_r;
  srm_mem_t    m_nxt;
  logic [15:0] wmask;

  // ----------------------------------------------------------------
  // byte lane mask
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign wmask[g*8 +: 8] = {8{port.be[g]}};
  end

  // registered read returns the old word during a write
  always_comb begin
    m_nxt       = m_r;
    m_nxt.rdata = m_r.word[port.addr];
    if (port.we) begin
      m_nxt.word[port.addr] = (m_r.word[port.addr] & ~wmask)
                            | (port.wdata & wmask);
    end
  end

  // storage only, so no reset is needed
  always_ff @(posedge clk) begin
    m_r <= m_nxt;
  end

  assign port.rdata = m_r.rdata;

endmodule

// File: hdl/srm_mac_unit.sv
`timescale 1ns/10ps

module srm_mac_unit (
  input  wire logic [15:0] op_a,
  input  wire logic [15:0] op_b,
  input  wire logic        frac,
  input  wire logic [39:0] acc,
  output logic      [39:0] sum,
  output logic             ovf
);

  logic signed [31:0] prod;
  logic        [31:0] scaled;
  logic        [39:0] ext;

  // ----------------------------------------------------------------
  // signed product, fractional alignment, accumulate
  // ----------------------------------------------------------------
  // fractional 0x8000 squared wraps; no product clipping here
  assign prod   = $signed(op_a) * $signed(op_b);
  assign scaled = frac ? {prod[30:0], 1'b0} : prod;
  assign ext    = {{8{scaled[31]}}, scaled};
  assign sum    = acc + ext;
  // true 40-bit overflow: equal signs in, other sign out
  assign ovf    = (acc[39] == ext[39]) && (sum[39] != acc[39]);

endmodule

// File: hdl/srm_exec_top.sv
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "srm_defines.svh"

module srm_exec_top import srm_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [8:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             busy_o
);

  srm_regs_t   r_r;
  srm_regs_t   r_nxt;
  srm_mem_if   mif();

  logic [23:0] ir;
  logic        byte_op;
  logic [15:0] step;
  logic        is_lsrf;
  logic        is_lsrw;
  logic        is_lsrk;
  logic        is_lsrr;
  logic        is_mac;
  logic        is_sqr;
  logic        legal;
  logic [15:0] src_ea;
  logic [15:0] rd1_ea;
  logic [3:0]  xi;
  logic [3:0]  yj;
  logic [3:0]  xidx;
  logic [3:0]  yidx;
  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic [3:0]  fai;
  logic [3:0]  fbi;
  logic [39:0] acc_in;
  logic [39:0] mac_sum;
  logic        mac_ovf;
  logic [31:0] st_word;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // effective address seen before any pointer update
  function automatic logic [15:0] pre_ea(input logic [15:0] a,
                                         input logic [2:0]  m,
                                         input logic [15:0] s);
    if (m == `SRM_AM_PREINC) return a + s;
    if (m == `SRM_AM_PREDEC) return a - s;
    return a;
  endfunction

  // pointer value left behind by the addressing mode
  function automatic logic [15:0] post_w(input logic [15:0] a,
                                         input logic [2:0]  m,
                                         input logic [15:0] s);
    if (m == `SRM_AM_POSTINC || m == `SRM_AM_PREINC) return a + s;
    if (m == `SRM_AM_POSTDEC || m == `SRM_AM_PREDEC) return a - s;
    return a;
  endfunction

  // prefetch post-adjust -6..+6 in bytes
  function automatic logic [15:0] pf_step(input logic [2:0] k);
    case (k)
      3'h1:    return 16'h0002;
      3'h2:    return 16'h0004;
      3'h3:    return 16'h0006;
      3'h5:    return 16'hfffa;
      3'h6:    return 16'hfffc;
      3'h7:    return 16'hfffe;
      default: return 16'h0000;
    endcase
  endfunction

  // byte-enable merge for bus writes
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) m[b*8 +: 8] = d[b*8 +: 8];
    end
    return m;
  endfunction

  // guard bits hold more than sign extension
  function automatic logic acc_ovf(input logic [39:0] a);
    return a[39:31] != {9{a[31]}};
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign ir      = r_r.ir;
  assign byte_op = ir[14];
  assign step    = byte_op ? `SRM_BYTE_STEP : `SRM_WORD_STEP;
  assign is_lsrf = ir[23:15] == `SRM_OP_LSRF;
  assign is_lsrw = ir[23:15] == `SRM_OP_LSRW;
  assign is_lsrk = ir[23:15] == `SRM_OP_LSRM
                && ir[6:4] == `SRM_LSR_LIT;
  assign is_lsrr = ir[23:15] == `SRM_OP_LSRM
                && ir[6:4] == `SRM_LSR_CNT;
  // pair codes 011 and 111 are not valid pairs
  assign is_mac  = ir[23:19] == `SRM_OP_MAC && !ir[14]
                && ir[17:16] != 2'h3;
  assign is_sqr  = ir[23:18] == `SRM_OP_SQR && !ir[14]
                && ir[1:0] == 2'h0;
  assign legal   = is_lsrf | is_lsrw | is_lsrk | is_lsrr
                 | is_mac | is_sqr;

  // operand addresses for the two read slots
  assign src_ea = pre_ea(r_r.w[ir[3:0]], ir[6:4], step);
  assign xi     = ir[9:6];
  assign yj     = ir[5:2];
  assign xidx   = {`SRM_XPTR_HI, xi[3]};
  assign yidx   = {`SRM_YPTR_HI, yj[3]};
  assign x_ea   = (xi == `SRM_PF_OFS)
                ? r_r.w[xidx] + r_r.w[`SRM_DEFAULT_WORK_REG_OFS]
                : r_r.w[xidx];
  assign y_ea   = (yj == `SRM_PF_OFS)
                ? r_r.w[yidx] + r_r.w[`SRM_DEFAULT_WORK_REG_OFS]
                : r_r.w[yidx];
  assign rd1_ea = is_lsrf ? {3'h0, ir[12:0]}
                : is_lsrw ? src_ea : x_ea;

  // factor pair: 45 46 47 56 57 67, or one register squared
  assign fai = is_sqr ? {`SRM_FACT_HI, ir[17:16]}
             : ir[18] ? (ir[17] ? 4'h6 : 4'h5) : 4'h4;
  assign fbi = is_sqr ? fai
             : ir[18] ? (ir[17:16] == 2'h0 ? 4'h6 : 4'h7)
             : 4'h5 + {2'h0, ir[17:16]};
  assign acc_in = ir[15] ? r_r.accumulator_two : r_r.accumulator_one;

  srm_mac_unit u_mac (
    .op_a (r_r.w[fai]),
    .op_b (r_r.w[fbi]),
    .frac (~r_r.ccr[`SRM_CCR_IF]),
    .acc  (acc_in),
    .sum  (mac_sum),
    .ovf  (mac_ovf)
  );

  srm_dmem u_mem (
    .clk  (clk),
    .port (mif.mem)
  );

  // status word as software sees it
  always_comb begin
    st_word              = 32'h0;
    st_word[`SRM_ST_C]   = r_r.fc;
    st_word[`SRM_ST_Z]   = r_r.fz;
    st_word[`SRM_ST_N]   = r_r.fn;
    st_word[`SRM_ST_ILL] = r_r.ill;
    st_word[`SRM_ST_BUSY] = r_r.busy;
    st_word[`SRM_ST_SAB] = r_r.sa | r_r.sb;
    st_word[`SRM_ST_OAB] = r_r.oa | r_r.ob;
    st_word[`SRM_ST_SB]  = r_r.sb;
    st_word[`SRM_ST_SA]  = r_r.sa;
    st_word[`SRM_ST_OB]  = r_r.ob;
    st_word[`SRM_ST_OA]  = r_r.oa;
  end

  // ----------------------------------------------------------------
  // next state: bus slave and execution sequence
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] op;
    logic [15:0] sh;
    logic [15:0] sa16;
    logic [15:0] dw;
    logic [15:0] dea;
    logic [15:0] res;
    logic [15:0] rnd;
    logic [39:0] other;
    logic [31:0] wd;
    logic [4:0]  cnt;
    logic [3:0]  di;
    logic        src_dir;
    op      = 16'h0;
    sh      = 16'h0;
    sa16    = 16'h0;
    dw      = 16'h0;
    dea     = 16'h0;
    res     = 16'h0;
    rnd     = 16'h0;
    other   = 40'h0;
    wd      = 32'h0;
    cnt     = 5'h0;
    di      = 4'h0;
    src_dir = 1'b0;
    r_nxt     = r_r;
    mif.addr  = '0;
    mif.wdata = 16'h0;
    mif.be    = 2'h0;
    mif.we    = 1'b0;

    // bus: request only taken while the core is idle
    unique case (r_r.bph)
      2'h0: begin
        if (wb_cyc_i && wb_stb_i && r_r.st == SRM_IDLE) begin
          mif.addr  = wb_adr_i[7:2];
          r_nxt.bph = 2'h1;
        end
      end
      2'h1: begin
        if (wb_adr_i[`SRM_MEM_BIT]) begin
          wd = {16'h0, mif.rdata};
        end else if (wb_adr_i[8:6] == `SRM_DEFAULT_WORK_REG_PAGE) begin
          wd = {16'h0, r_r.w[wb_adr_i[5:2]]};
        end else begin
          case (wb_adr_i)
            `SRM_OFF_INSTR:   wd = {8'h0, r_r.ir};
            `SRM_OFF_STATUS:  wd = st_word;
            `SRM_OFF_CCR:     wd = {16'h0, r_r.ccr};
            `SRM_OFF_ACCUMULATOR_ONE_LO: wd = r_r.accumulator_one[31:0];
            `SRM_OFF_ACCUMULATOR_ONE_HI: wd = {24'h0, r_r.accumulator_one[39:32]};
            `SRM_OFF_ACCUMULATOR_TWO_LO: wd = r_r.accumulator_two[31:0];
            `SRM_OFF_ACCUMULATOR_TWO_HI: wd = {24'h0, r_r.accumulator_two[39:32]};
            default:          wd = 32'h0;
          endcase
        end
        r_nxt.dat = wd;
        r_nxt.ack = 1'b1;
        r_nxt.bph = 2'h2;
      end
      2'h2: begin
        // writes land on the edge that the master samples ack
        r_nxt.ack = 1'b0;
        r_nxt.bph = 2'h0;
        if (wb_we_i) begin
          if (wb_adr_i[`SRM_MEM_BIT]) begin
            mif.addr  = wb_adr_i[7:2];
            mif.wdata = wb_dat_i[15:0];
            mif.be    = wb_sel_i[1:0];
            mif.we    = 1'b1;
          end else if (wb_adr_i[8:6] == `SRM_DEFAULT_WORK_REG_PAGE) begin
            wd = merge({16'h0, r_r.w[wb_adr_i[5:2]]}, wb_dat_i,
                       wb_sel_i);
            r_nxt.w[wb_adr_i[5:2]] = wd[15:0];
          end else begin
            case (wb_adr_i)
              `SRM_OFF_INSTR: begin
                wd       = merge({8'h0, r_r.ir}, wb_dat_i, wb_sel_i);
                r_nxt.ir = wd[23:0];
                r_nxt.st = SRM_RD1;
              end
              `SRM_OFF_STATUS: begin
                if (wb_sel_i[0]) begin
                  r_nxt.fc = wb_dat_i[`SRM_ST_C];
                  r_nxt.fz = wb_dat_i[`SRM_ST_Z];
                  r_nxt.fn = wb_dat_i[`SRM_ST_N];
                  if (wb_dat_i[`SRM_ST_ILL]) r_nxt.ill = 1'b0;
                end
                if (wb_sel_i[1] && wb_dat_i[`SRM_ST_SA])
                  r_nxt.sa = 1'b0;
                if (wb_sel_i[1] && wb_dat_i[`SRM_ST_SB])
                  r_nxt.sb = 1'b0;
              end
              `SRM_OFF_CCR: begin
                wd        = merge({16'h0, r_r.ccr}, wb_dat_i, wb_sel_i);
                r_nxt.ccr = wd[15:0];
              end
              `SRM_OFF_ACCUMULATOR_ONE_LO:
                r_nxt.accumulator_one[31:0] = merge(r_r.accumulator_one[31:0], wb_dat_i,
                                         wb_sel_i);
              `SRM_OFF_ACCUMULATOR_ONE_HI:
                if (wb_sel_i[0]) r_nxt.accumulator_one[39:32] = wb_dat_i[7:0];
              `SRM_OFF_ACCUMULATOR_TWO_LO:
                r_nxt.accumulator_two[31:0] = merge(r_r.accumulator_two[31:0], wb_dat_i,
                                         wb_sel_i);
              `SRM_OFF_ACCUMULATOR_TWO_HI:
                if (wb_sel_i[0]) r_nxt.accumulator_two[39:32] = wb_dat_i[7:0];
              default: ;
            endcase
          end
        end
      end
      default: r_nxt.bph = 2'h0;
    endcase

    // fixed three-step pass so every form retires alike
    unique case (r_r.st)
      SRM_IDLE: ;
      SRM_RD1: begin
        if (!legal) begin
          r_nxt.ill = 1'b1;
          r_nxt.st  = SRM_IDLE;
        end else begin
          mif.addr = rd1_ea[6:1];
          r_nxt.st = SRM_RD2;
        end
      end
      SRM_RD2: begin
        r_nxt.d1 = mif.rdata;
        mif.addr = y_ea[6:1];
        r_nxt.st = SRM_EXEC;
      end
      SRM_EXEC: begin
        r_nxt.st = SRM_IDLE;
        if (is_lsrf || is_lsrw) begin
          src_dir = is_lsrw && ir[6:4] == `SRM_AM_DIR;
          sa16    = is_lsrf ? {3'h0, ir[12:0]} : src_ea;
          op      = src_dir ? r_r.w[ir[3:0]] : r_r.d1;
          // odd byte address takes the upper lane
          if (byte_op && !src_dir && sa16[0]) op = {8'h0, op[15:8]};
          sh = byte_op ? {8'h0, 1'b0, op[7:1]}
                       : {1'b0, op[15:1]};
          r_nxt.fc = op[0];
          r_nxt.fn = byte_op ? sh[7] : sh[15];
          r_nxt.fz = byte_op ? sh[7:0] == 8'h0
                             : sh == 16'h0;
          if (is_lsrw)
            r_nxt.w[ir[3:0]] = post_w(r_r.w[ir[3:0]], ir[6:4], step);
          di  = is_lsrf ? `SRM_DEFAULT_WORK_REG_DEF : ir[10:7];
          dw  = r_nxt.w[di];
          dea = is_lsrf ? sa16 : pre_ea(dw, ir[13:11], step);
          if (is_lsrf ? !ir[13] : ir[13:11] == `SRM_AM_DIR) begin
            r_nxt.w[di] = byte_op ? {dw[15:8], sh[7:0]} : sh;
          end else begin
            mif.addr  = dea[6:1];
            mif.wdata = byte_op ? {sh[7:0], sh[7:0]} : sh;
            mif.be    = !byte_op ? 2'h3 : (dea[0] ? 2'h2 : 2'h1);
            mif.we    = 1'b1;
            if (is_lsrw) r_nxt.w[di] = post_w(dw, ir[13:11], step);
          end
        end else if (is_lsrk || is_lsrr) begin
          cnt = is_lsrk ? {1'b0, ir[3:0]}
                        : r_r.w[ir[3:0]][4:0];
          res = (cnt > `SRM_MAX_SHIFT) ? 16'h0
              : r_r.w[ir[14:11]] >> cnt[3:0];
          r_nxt.w[ir[10:7]] = res;
          r_nxt.fn = res[15];
          r_nxt.fz = res == 16'h0;
        end else begin
          if (ir[15]) begin
            r_nxt.accumulator_two = mac_sum;
            r_nxt.sb   = r_r.sb | mac_ovf;
          end else begin
            r_nxt.accumulator_one = mac_sum;
            r_nxt.sa   = r_r.sa | mac_ovf;
          end
          r_nxt.oa = acc_ovf(r_nxt.accumulator_one);
          r_nxt.ob = acc_ovf(r_nxt.accumulator_two);
          // prefetch loads use values read in the two read slots
          if (xi != `SRM_PF_NONE) begin
            r_nxt.w[{`SRM_FACT_HI, ir[13:12]}] = r_r.d1;
            if (xi != `SRM_PF_OFS)
              r_nxt.w[xidx] = r_r.w[xidx] + pf_step(xi[2:0]);
          end
          if (yj != `SRM_PF_NONE) begin
            r_nxt.w[{`SRM_FACT_HI, ir[11:10]}] = mif.rdata;
            if (yj != `SRM_PF_OFS)
              r_nxt.w[yidx] = r_r.w[yidx] + pf_step(yj[2:0]);
          end
          // write-back of the accumulator not being summed into
          other = ir[15] ? r_r.accumulator_one : r_r.accumulator_two;
          rnd   = other[31:16] + {15'h0, other[15]};
          if (is_mac && ir[1:0] == `SRM_AWB_REG) begin
            r_nxt.w[`SRM_DEFAULT_WORK_REG_AWB] = rnd;
          end else if (is_mac && ir[1:0] == `SRM_AWB_MEM) begin
            mif.addr  = r_r.w[`SRM_DEFAULT_WORK_REG_AWB][6:1];
            mif.wdata = rnd;
            mif.be    = 2'h3;
            mif.we    = 1'b1;
            r_nxt.w[`SRM_DEFAULT_WORK_REG_AWB] = r_r.w[`SRM_DEFAULT_WORK_REG_AWB]
                                   + `SRM_WORD_STEP;
          end
        end
      end
    endcase
    r_nxt.busy = r_nxt.st != SRM_IDLE;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r     <= '0;
      r_r.ccr <= `SRM_CCR_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign wb_dat_o = r_r.dat;
  assign wb_ack_o = r_r.ack;
  assign busy_o   = r_r.busy;

endmodule

// File: testbench/srm_exec_sva.sv
`timescale 1ns/10ps
module srm_exec_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [8:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        busy_o
);
  // single domain, async reset quiets all checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // bus answers and instruction pacing
  a_ack_two_late: assert property ($rose(wb_cyc_i && wb_stb_i) &&
    !busy_o |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o)
    else $error("ack timing");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_has_req: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  a_no_ack_busy: assert property (busy_o |-> !wb_ack_o)
    else $error("ack while busy");
  a_instr_starts: assert property (wb_ack_o && wb_we_i &&
    wb_adr_i[8:2] == 7'h00 |=> busy_o) else $error("no busy");
  a_busy_cause: assert property ($rose(busy_o) |->
    $past(wb_ack_o) && $past(wb_we_i)) else $error("stray busy");
  a_one_instr: assert property (busy_o[*3] |=> !busy_o)
    else $error("busy too long");
  a_hole_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[8:5] == 4'h1 |-> wb_dat_o == 32'h0) else $error("hole");
  c_instr: cover property ($rose(busy_o) ##3 !busy_o);
  c_illegal: cover property ($rose(busy_o) ##1 !busy_o);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule

bind srm_exec_top srm_exec_sva sva_u (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));

// File: testbench/shift_right_and_mac_exec_tb_top.sv
`timescale 1ns/10ps
module shift_right_and_mac_exec_tb_top;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, ab, z;
  logic [8:0]  adr = 9'h0;
  logic [31:0] dw = 32'h0, dr, rd, pr;
  logic        ack, busy;
  logic [15:0] v, o, e, wv[8];
  logic [39:0] acc[2] = '{40'h0, 40'h0};
  logic [2:0]  m, i, j;
  int          errors = 0, comparisons = 0;

  srm_exec_top dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .busy_o(busy));

  // 100 MHz clock
  initial forever #5 clk = ~clk;

  task automatic check(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      errors++;
      $display("Error %0t: saw %h want %h", $time, s, x);
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // classic cycle; a busy core stalls it, hence the bound
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    for (n = 0; n < 40 && ack !== 1'b1; n++)
      @(posedge clk);
    check(n < 40, 1'b1);
    if (n == 40)
      stop_test();
    rd = dr;
    cyc <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    void'($urandom(59));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, 9'h020, 32'h0); // hole in the map
    wb(1'b1, 9'h004, 32'h1); // carry preset, must survive
    for (int n = 0; n < 32; n++) begin
      v = (n == 3) ? 16'h0007 : 16'($urandom);
      e = (n > 15) ? 16'h0 : v >> n;
      wb(1'b1, 9'h044, {16'h0, v});
      wb(1'b1, 9'h04c, {21'($urandom), 5'(n)});
      if (n < 16) begin
        wb(1'b1, 9'h000, {8'h0, 20'hde094, 4'(n)});
        wb(1'b0, 9'h048, 32'h0);
        check(rd[15:0], e);
      end
      wb(1'b1, 9'h000, 32'h00de0903);
      wb(1'b0, 9'h048, 32'h0);
      check(rd[15:0], e);
      wb(1'b0, 9'h004, 32'h0);
      check(rd[2:0], {e[15], e == 16'h0, 1'b1});
    end
    // bit2 picks source form, bit1 byte, bit0 file destination in file form
    for (int k = 0; k < 8; k++) begin
      v = (k == 5) ? 16'h0001 : 16'($urandom);
      o = (k[2] || !k[0]) ? 16'($urandom) : v;
      e = k[1] ? {o[15:8], 1'b0, v[7:1]} : {1'b0, v[15:1]};
      z = k[1] ? e[7:0] == 8'h0 : e == 16'h0;
      if (k[2]) begin
        wb(1'b1, 9'h058, {16'h0, o});
        wb(1'b1, 9'h054, {16'h0, v});
        wb(1'b1, 9'h000, {8'h0, 8'hd1, 1'b0, k[1], 14'h0305});
        wb(1'b0, 9'h058, 32'h0);
      end else begin
        wb(1'b1, 9'h040, {16'h0, o});
        wb(1'b1, 9'h104, {16'h0, v});
        wb(1'b1, 9'h000, {8'h0, 8'hd5, 1'b0, k[1], k[0], 13'h0002});
        wb(1'b0, k[0] ? 9'h104 : 9'h040, 32'h0);
      end
      check(rd[15:0], e);
      wb(1'b0, 9'h004, 32'h0);
      check(rd[2:0], {1'b0, z, v[0]});
    end
    // legal pairs, then a fractional pass, then an illegal pair
    for (int p = 0; p < 8; p++) begin
      m = (p > 5) ? 3'(p * 3 - 18) : 3'(p + (p > 2));
      i = (m < 3'h3) ? 3'h4 : 3'h5 + 3'(m == 3'h6);
      j = (m < 3'h3) ? m + 3'h5 : (m == 3'h6 ? 3'h7 : m + 3'h2);
      ab = 1'($urandom);
      for (int r = 4; r < 8; r++) begin
        wv[r] = 16'($urandom);
        wb(1'b1, {3'h1, 4'(r), 2'h0}, {16'h0, wv[r]});
      end
      wb(1'b1, 9'h008, {31'h0, p < 6});
      wb(1'b1, 9'h000, {8'h0, 5'h18, m, ab, 15'h0112});
      pr = $signed(wv[i]) * $signed(wv[j]);
      if (p == 6) pr = pr << 1;
      if (p < 7) acc[ab] = acc[ab] + {{8{pr[31]}}, pr};
      for (int q = 0; q < 2; q++) begin
        wb(1'b0, 9'h00c + 9'(q * 8), 32'h0);
        check(rd, acc[q][31:0]);
        wb(1'b0, 9'h010 + 9'(q * 8), 32'h0);
        check(rd[7:0], acc[q][39:32]);
      end
    end
    wb(1'b0, 9'h004, 32'h0);
    check(rd[3], 1'b1);
    // square with X post-adjust and Y offset prefetch, then write-back
    v = 16'($urandom);
    o = 16'($urandom);
    e = 16'($urandom);
    wb(1'b1, 9'h008, 32'h1);
    wb(1'b1, 9'h050, {16'h0, v});
    wb(1'b1, 9'h120, {16'h0, o});
    wb(1'b1, 9'h140, {16'h0, e});
    wb(1'b1, 9'h060, 32'h10);
    wb(1'b1, 9'h06c, 32'h14);
    wb(1'b1, 9'h070, 32'h0c);
    wb(1'b1, 9'h074, 32'h30);
    wb(1'b1, 9'h000, 32'h00f018f0);
    pr = $signed(v) * $signed(v);
    acc[0] = acc[0] + {{8{pr[31]}}, pr};
    wb(1'b0, 9'h054, 32'h0);
    check(rd[15:0], o);
    wb(1'b0, 9'h058, 32'h0);
    check(rd[15:0], e);
    wb(1'b0, 9'h060, 32'h0);
    check(rd[15:0], 16'h0016);
    wb(1'b0, 9'h06c, 32'h0);
    check(rd[15:0], 16'h0014);
    wb(1'b0, 9'h00c, 32'h0);
    check(rd, acc[0][31:0]);
    wb(1'b1, 9'h000, 32'h00c08111);
    pr = $signed(v) * $signed(o);
    acc[1] = acc[1] + {{8{pr[31]}}, pr};
    wb(1'b0, 9'h160, 32'h0);
    check(rd[15:0], 16'(acc[0][31:16] + acc[0][15]));
    wb(1'b0, 9'h074, 32'h0);
    check(rd[15:0], 16'h0032);
    wb(1'b0, 9'h014, 32'h0);
    check(rd, acc[1][31:0]);
    // push accumulator one past its top, then clear its clipped flag
    wb(1'b1, 9'h00c, 32'hffffffff);
    wb(1'b1, 9'h010, 32'h7f);
    wb(1'b1, 9'h050, {16'h0, v | 16'h1});
    wb(1'b1, 9'h000, 32'h00f00110);
    wb(1'b0, 9'h004, 32'h0);
    check({rd[13], rd[11], rd[9:8]}, 4'hf);
    wb(1'b1, 9'h004, 32'h800);
    wb(1'b0, 9'h004, 32'h0);
    check({rd[11], rd[13]}, 2'h1);
    stop_test();
  end
endmodule
